// [sync_cfg_map.vh]
`ifndef SYNC_CFG_MAP_VH
`define SYNC_CFG_MAP_VH
// register byte addresses
`define SC_ADDR_PULSE      12'h000
`define SC_ADDR_PHASE      12'h004
`define SC_ADDR_STATUS     12'h008
// sync pulse register fields
`define SC_SRC_BIT         7
`define SC_FR_INV_BIT      3
`define SC_FR_PULSE_BIT    2
`define SC_MF_INV_BIT      1
`define SC_MF_PULSE_BIT    0
`define SC_PULSE_MASK      8'h8f
`define SC_PULSE_RESET     8'h00
// sync phase register fields
`define SC_INDEP_BIT       7
`define SC_FINE_BIT        6
`define SC_PHASE_LSB       0
`define SC_PHASE_MASK      8'hc3
`define SC_PHASE_RESET     8'h00
// sampling phase codes
`define SC_PH_ON_TARGET    2'h0
`define SC_PH_HALF_EARLY   2'h1
`define SC_PH_ONE_LATE     2'h2
`define SC_PH_HALF_LATE    2'h3
// sample delay codes, half-ui steps around the nominal
`define SC_DLY_NOMINAL     3'h2
`define SC_DLY_HALF_EARLY  3'h1
`define SC_DLY_ONE_LATE    3'h4
`define SC_DLY_HALF_LATE   3'h3
// sample rate codes
`define SC_RATE_6M48       2'h0
`define SC_RATE_19M44      2'h1
`define SC_RATE_38M88      2'h2
// ahb transfer type
`define SC_HTRANS_NONSEQ   2'h2
`endif

// [sync_shaper.v]
`timescale 1ns/1ps
`default_nettype none
// turns a raw 50:50 sync into the programmed shape and polarity
module sync_shaper (
  // clock and reset
  input  wire clk_sys_i,
  input  wire reset_i,
  // controls
  input  wire pulsed_i,
  input  wire invert_i,
  input  wire out3_en_i,
  input  wire out3_tick_i,
  input  wire raw_i,
  // shaped output
  output reg  sync_o
);
  reg raw_q;
  reg arm_q;
  reg pulse_q;
  wire rise;
  assign rise = raw_i & ~raw_q;
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      raw_q   <= 1'b0;
      arm_q   <= 1'b0;
      pulse_q <= 1'b0;
      sync_o  <= 1'b0;
    end else begin
      raw_q <= raw_i;
      // a rise only arms: opening on a tick and closing on the next one gives
      // a whole third-output period, not the remainder of the current one
      if (rise)
        arm_q <= 1'b1;
      else if (out3_tick_i)
        arm_q <= 1'b0;
      if (out3_tick_i)
        pulse_q <= arm_q;
      // without the third output enabled, pulsed mode has no width source: stay idle
      if (pulsed_i)
        sync_o <= (pulse_q & out3_en_i) ^ invert_i;
      else
        sync_o <= raw_q ^ invert_i;
    end
  end
endmodule // sync_shaper
`default_nettype wire

// [frame_sync_output_config.v]
// How it works
// - pulse reg bit 7 picks sync timing: 0 main dpll, 1 auxiliary dpll.
// - pulse reg bit 3 set inverts the 8 kHz frame sync output.
// - pulse reg bit 2 set makes frame sync pulsed, clear gives 50:50.
// - pulsed frame sync needs output 3 on; pulse is one output-3 period.
// - pulse reg bit 1 set inverts the 2 kHz multiframe sync output.
// - pulse reg bit 0 set makes multiframe sync pulsed, clear gives 50:50.
// - pulsed multiframe sync needs output 3 on; pulse is one output-3 period.
// - phase reg bit 7 clear keeps syncs aligned to clocks; set leaves clocks alone unless bit 6 is set.
// - phase reg bit 6 picks 6.48 MHz or fine 19.44/38.88 MHz sampling.
// - phase field 00 on target, 01 half early, 10 one late, 11 half late.
`timescale 1ns/1ps
`default_nettype none
`include "sync_cfg_map.vh"
module frame_sync_output_config (
  // clock and reset
  input  wire        clk_sys_i,
  input  wire        reset_i,
  // ahb-lite slave
  input  wire        hsel_i,
  input  wire [11:0] haddr_i,
  input  wire [1:0]  htrans_i,
  input  wire        hwrite_i,
  input  wire [2:0]  hsize_i,
  input  wire [31:0] hwdata_i,
  input  wire        hready_i,
  output reg  [31:0] hrdata_o,
  output wire        hreadyout_o,
  output wire        hresp_o,
  // raw 50:50 timing from both dplls
  input  wire        main_dpll_8k_i,
  input  wire        main_dpll_2k_i,
  input  wire        auxiliary_dpll_8k_i,
  input  wire        auxiliary_dpll_2k_i,
  // third output clock status
  input  wire        out3_en_i,
  input  wire        out3_clk_i,
  // external sync input and reference rate
  input  wire        external_sync_input_i,
  input  wire        ref_is_38m88_i,
  // sync outputs
  output wire        frame_sync_output_o,
  output wire        multiframe_sync_output_o,
  // general clock output timing and controls
  output reg         gen_8k_o,
  output reg         gen_2k_o,
  output reg         sync_resync_o,
  output reg         clocks_resync_o,
  output reg  [1:0]  sample_rate_sel_o,
  output reg  [2:0]  sample_delay_o
);
  reg [7:0]  sync_pulse_shape_config_q;
  reg [7:0]  sync_input_phase_config_q;
  reg        wr_pend_q;
  reg [11:0] addr_q;
  reg [1:0]  m8_s_q;
  reg [1:0]  m2_s_q;
  reg [1:0]  a8_s_q;
  reg [1:0]  a2_s_q;
  reg [1:0]  o3_s_q;
  reg        o3_prev_q;
  reg [1:0]  ext_s_q;
  reg        ext_prev_q;
  wire       src_aux;
  wire       raw_8k;
  wire       raw_2k;
  wire       out3_tick;
  wire       ext_fall;
  wire       addr_phase;
  wire       ext_level;
  wire       out3_level;
  wire [1:0] phase_field;
  reg  [31:0] rd_mux;

  // one decode serves both the write strobes and the read mux
  function reg_hit;
    input [11:0] addr;
    input [11:0] offset;
    begin
      reg_hit = (addr == offset);
    end
  endfunction

  // write data keeps only the implemented bits
  function [7:0] masked_byte;
    input [31:0] data;
    input [7:0]  mask;
    begin
      masked_byte = data[7:0] & mask;
    end
  endfunction

  // sampling phase field to half-ui delay steps
  function [2:0] delay_code;
    input [1:0] phase;
    begin
      case (phase)
        `SC_PH_ON_TARGET:  delay_code = `SC_DLY_NOMINAL;
        `SC_PH_HALF_EARLY: delay_code = `SC_DLY_HALF_EARLY;
        `SC_PH_ONE_LATE:   delay_code = `SC_DLY_ONE_LATE;
        `SC_PH_HALF_LATE:  delay_code = `SC_DLY_HALF_LATE;
        default:           delay_code = `SC_DLY_NOMINAL;
      endcase
    end
  endfunction

  // fine sampling follows whichever reference rate is current
  function [1:0] rate_code;
    input fine;
    input ref_38m88;
    begin
      if (!fine)
        rate_code = `SC_RATE_6M48;
      else if (ref_38m88)
        rate_code = `SC_RATE_38M88;
      else
        rate_code = `SC_RATE_19M44;
    end
  endfunction

  // two-stage capture of the dpll, output-3 clock and external sync inputs; only the second stage is read
  always @(posedge clk_sys_i) begin
    if (reset_i)
      m8_s_q <= 2'h0;
    else
      m8_s_q <= {m8_s_q[0], main_dpll_8k_i};
  end

  always @(posedge clk_sys_i) begin
    if (reset_i)
      m2_s_q <= 2'h0;
    else
      m2_s_q <= {m2_s_q[0], main_dpll_2k_i};
  end

  always @(posedge clk_sys_i) begin
    if (reset_i)
      a8_s_q <= 2'h0;
    else
      a8_s_q <= {a8_s_q[0], auxiliary_dpll_8k_i};
  end

  always @(posedge clk_sys_i) begin
    if (reset_i)
      a2_s_q <= 2'h0;
    else
      a2_s_q <= {a2_s_q[0], auxiliary_dpll_2k_i};
  end

  always @(posedge clk_sys_i) begin
    if (reset_i)
      o3_s_q <= 2'h0;
    else
      o3_s_q <= {o3_s_q[0], out3_clk_i};
  end

  always @(posedge clk_sys_i) begin
    if (reset_i)
      ext_s_q <= 2'h0;
    else
      ext_s_q <= {ext_s_q[0], external_sync_input_i};
  end

  assign out3_level = o3_s_q[1];
  assign ext_level  = ext_s_q[1];

  // edge detector history resets low, so a sync input that sits high
  // at release can never fake a falling edge and a spurious resync
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      o3_prev_q  <= 1'b0;
      ext_prev_q <= 1'b0;
    end else begin
      o3_prev_q  <= out3_level;
      ext_prev_q <= ext_level;
    end
  end

  assign out3_tick = o3_s_q[1] & ~o3_prev_q;
  // the source is expected to align its falling edge near the reference edge
  assign ext_fall  = ext_prev_q & ~ext_s_q[1];

  assign src_aux = sync_pulse_shape_config_q[`SC_SRC_BIT];
  assign raw_8k  = src_aux ? a8_s_q[1] : m8_s_q[1];
  assign raw_2k  = src_aux ? a2_s_q[1] : m2_s_q[1];

  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      gen_8k_o <= 1'b0;
      gen_2k_o <= 1'b0;
    end else begin
      gen_8k_o <= raw_8k;
      gen_2k_o <= raw_2k;
    end
  end

  sync_shaper u_frame (
    .clk_sys_i   (clk_sys_i),
    .reset_i     (reset_i),
    .pulsed_i    (sync_pulse_shape_config_q[`SC_FR_PULSE_BIT]),
    .invert_i    (sync_pulse_shape_config_q[`SC_FR_INV_BIT]),
    .out3_en_i   (out3_en_i),
    .out3_tick_i (out3_tick),
    .raw_i       (raw_8k),
    .sync_o      (frame_sync_output_o)
  );

  sync_shaper u_multiframe (
    .clk_sys_i   (clk_sys_i),
    .reset_i     (reset_i),
    .pulsed_i    (sync_pulse_shape_config_q[`SC_MF_PULSE_BIT]),
    .invert_i    (sync_pulse_shape_config_q[`SC_MF_INV_BIT]),
    .out3_en_i   (out3_en_i),
    .out3_tick_i (out3_tick),
    .raw_i       (raw_2k),
    .sync_o      (multiframe_sync_output_o)
  );

  // resync strobe on each external sync falling edge
  always @(posedge clk_sys_i) begin
    if (reset_i)
      sync_resync_o <= 1'b0;
    else
      sync_resync_o <= ext_fall;
  end

  // independent mode leaves the other clocks alone, but fine sampling
  // still pulls the derived clocks along with the sync input
  always @(posedge clk_sys_i) begin
    if (reset_i)
      clocks_resync_o <= 1'b0;
    else
      clocks_resync_o <= ext_fall & (~sync_input_phase_config_q[`SC_INDEP_BIT]
                         | sync_input_phase_config_q[`SC_FINE_BIT]);
  end

  always @(posedge clk_sys_i) begin
    if (reset_i)
      sample_rate_sel_o <= `SC_RATE_6M48;
    else
      sample_rate_sel_o <= rate_code(sync_input_phase_config_q[`SC_FINE_BIT],
                                     ref_is_38m88_i);
  end

  assign phase_field = sync_input_phase_config_q[`SC_PHASE_LSB+1:`SC_PHASE_LSB];

  always @(posedge clk_sys_i) begin
    if (reset_i)
      sample_delay_o <= `SC_DLY_NOMINAL;
    else
      sample_delay_o <= delay_code(phase_field);
  end

  // ahb-lite: zero wait states, always okay
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;
  assign addr_phase  = hsel_i & hready_i & (htrans_i == `SC_HTRANS_NONSEQ);

  // address phase captured for the data phase that follows
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      wr_pend_q <= 1'b0;
      addr_q    <= 12'h000;
    end else if (hready_i) begin
      wr_pend_q <= addr_phase & hwrite_i;
      addr_q    <= haddr_i;
    end
  end

  // writes land in the data phase; unused bits are never stored
  always @(posedge clk_sys_i) begin
    if (reset_i)
      sync_pulse_shape_config_q <= `SC_PULSE_RESET;
    else if (wr_pend_q & reg_hit(addr_q, `SC_ADDR_PULSE))
      sync_pulse_shape_config_q <= masked_byte(hwdata_i, `SC_PULSE_MASK);
  end

  always @(posedge clk_sys_i) begin
    if (reset_i)
      sync_input_phase_config_q <= `SC_PHASE_RESET;
    else if (wr_pend_q & reg_hit(addr_q, `SC_ADDR_PHASE))
      sync_input_phase_config_q <= masked_byte(hwdata_i, `SC_PHASE_MASK);
  end

  // read mux; unmapped offsets read as zero
  always @* begin
    rd_mux = 32'h0000_0000;
    if (reg_hit(haddr_i, `SC_ADDR_PULSE))
      rd_mux = {24'h000000, sync_pulse_shape_config_q};
    else if (reg_hit(haddr_i, `SC_ADDR_PHASE))
      rd_mux = {24'h000000, sync_input_phase_config_q};
    else if (reg_hit(haddr_i, `SC_ADDR_STATUS))
      rd_mux = {26'h0, ext_level, out3_en_i, multiframe_sync_output_o,
                frame_sync_output_o, gen_2k_o, gen_8k_o};
  end

  // registered at the address phase so it already stands in the data phase
  always @(posedge clk_sys_i) begin
    if (reset_i)
      hrdata_o <= 32'h0000_0000;
    else if (addr_phase & ~hwrite_i)
      hrdata_o <= rd_mux;
  end
endmodule // frame_sync_output_config
`default_nettype wire

// [sync_far_side.sv]
`timescale 1ns/1ps
`default_nettype none
// both dplls, the third output clock and the external sync source
module sync_far_side (
  // raw timing, shortened periods so a run stays brief
  output var logic main_8k_o,
  output var logic main_2k_o,
  output var logic aux_8k_o,
  output var logic aux_2k_o,
  output var logic out3_clk_o,
  output wire logic ext_sync_o
);
  // ext sync falls exactly on a main timing edge, inside the half-ui margin
  assign ext_sync_o = main_2k_o;
  initial begin
    {main_8k_o, main_2k_o, aux_8k_o, aux_2k_o, out3_clk_o} = 5'h00;
    #3;
    fork
      forever #400 main_8k_o = ~main_8k_o;
      forever #1600 main_2k_o = ~main_2k_o;
      forever #560 aux_8k_o = ~aux_8k_o;
      forever #2240 aux_2k_o = ~aux_2k_o;
      forever #30 out3_clk_o = ~out3_clk_o;
    join
  end
endmodule // sync_far_side
`default_nettype wire

// [sync_cfg_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
`include "sync_cfg_map.vh"
module sync_cfg_checker (
  // clock, reset and bus
  input wire logic        clk_sys_i,
  input wire logic        reset_i,
  input wire logic        hsel_i,
  input wire logic        hwrite_i,
  input wire logic        hready_i,
  input wire logic [1:0]  htrans_i,
  input wire logic [11:0] haddr_i,
  input wire logic [31:0] hwdata_i,
  input wire logic [31:0] hrdata_o,
  input wire logic        hreadyout_o,
  input wire logic        hresp_o,
  // sync side
  input wire logic        out3_en_i,
  input wire logic        ref_is_38m88_i,
  input wire logic        frame_sync_output_o,
  input wire logic        multiframe_sync_output_o,
  input wire logic        sync_resync_o,
  input wire logic        clocks_resync_o,
  input wire logic [1:0]  sample_rate_sel_o,
  input wire logic [2:0]  sample_delay_o
);
  logic        wr_q;
  logic        rd_q;
  logic [11:0] a_q;
  logic [7:0]  pul_q;
  logic [7:0]  ph_q;
  // shadow copies of both registers, masked as the real ones
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      pul_q <= 8'h00;
      ph_q <= 8'h00;
    end else begin
      wr_q <= hsel_i && hready_i && htrans_i == `SC_HTRANS_NONSEQ && hwrite_i;
      rd_q <= hsel_i && hready_i && htrans_i == `SC_HTRANS_NONSEQ && !hwrite_i;
      a_q <= haddr_i;
      if (wr_q && a_q == `SC_ADDR_PULSE) pul_q <= hwdata_i[7:0] & `SC_PULSE_MASK;
      if (wr_q && a_q == `SC_ADDR_PHASE) ph_q <= hwdata_i[7:0] & `SC_PHASE_MASK;
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  bus_okay_a: assert property (hreadyout_o && !hresp_o) else $error("bus answer not okay");
  read_back_a: assert property (rd_q && a_q == `SC_ADDR_PULSE |->
    hrdata_o == {24'h0, $past(pul_q)}) else $error("pulse register readback wrong");
  phase_back_a: assert property (rd_q && a_q == `SC_ADDR_PHASE |->
    hrdata_o == {24'h0, $past(ph_q)}) else $error("phase register readback wrong");
  delay_map_a: assert property (($stable(ph_q))[*3] |-> sample_delay_o ==
    (ph_q[1:0] == 2'h0 ? 3'h2 : ph_q[1:0] == 2'h1 ? 3'h1 : ph_q[1:0] == 2'h2 ? 3'h4 : 3'h3))
    else $error("sample delay wrong");
  rate_sel_a: assert property (($stable(ph_q) && $stable(ref_is_38m88_i))[*3] |->
    sample_rate_sel_o == (!ph_q[6] ? 2'h0 : ref_is_38m88_i ? 2'h2 : 2'h1))
    else $error("sample rate wrong");
  clock_resync_a: assert property (($stable(ph_q))[*3] |->
    clocks_resync_o == (sync_resync_o && (!ph_q[7] || ph_q[6]))) else $error("clock resync wrong");
  resync_pulse_a: assert property (sync_resync_o |=> !sync_resync_o) else $error("resync too long");
  frame_idle_a: assert property (($stable(pul_q) && pul_q[2] && !out3_en_i)[*8] |->
    frame_sync_output_o == pul_q[3]) else $error("frame sync not idle");
  mf_idle_a: assert property (($stable(pul_q) && pul_q[0] && !out3_en_i)[*8] |->
    multiframe_sync_output_o == pul_q[1]) else $error("multiframe sync not idle");
  cover property (rd_q && a_q == `SC_ADDR_PHASE);
  cover property (clocks_resync_o);
  cover property (sync_resync_o && !clocks_resync_o);
endmodule // sync_cfg_checker
bind frame_sync_output_config sync_cfg_checker chk (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
  .hsel_i(hsel_i), .hwrite_i(hwrite_i), .hready_i(hready_i), .htrans_i(htrans_i),
  .haddr_i(haddr_i), .hwdata_i(hwdata_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
  .hresp_o(hresp_o), .out3_en_i(out3_en_i), .ref_is_38m88_i(ref_is_38m88_i),
  .frame_sync_output_o(frame_sync_output_o), .multiframe_sync_output_o(multiframe_sync_output_o),
  .sync_resync_o(sync_resync_o), .clocks_resync_o(clocks_resync_o),
  .sample_rate_sel_o(sample_rate_sel_o), .sample_delay_o(sample_delay_o));
`default_nettype wire

// [frame_sync_output_config_bench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "sync_cfg_map.vh"
module frame_sync_output_config_bench;
  logic clk_sys_i = 1'b0, reset_i = 1'b1, hsel_i = 1'b0, hwrite_i = 1'b0;
  logic out3_en_i = 1'b0, ref_is_38m88_i = 1'b0;
  logic [11:0] haddr_i = 12'h000;
  logic [1:0]  htrans_i = 2'h0;
  logic [31:0] hwdata_i = 32'h0, rdv;
  wire  [31:0] hrdata_o;
  wire  hreadyout_o, hresp_o, m8, m2, a8, a2, o3, ext, fr, mf, g8, g2, rs, crs;
  wire  [1:0] rate;
  wire  [2:0] dly;
  integer miscompares = 0, checks = 0, cycles = 0, n, w, i;
  // third output period in system clocks: 60 ns from the far side against 20 ns
  localparam int O3_CYCLES = 3;
  sync_far_side far (.main_8k_o(m8), .main_2k_o(m2), .aux_8k_o(a8), .aux_2k_o(a2),
    .out3_clk_o(o3), .ext_sync_o(ext));
  frame_sync_output_config DUT (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2),
    .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .main_dpll_8k_i(m8), .main_dpll_2k_i(m2), .auxiliary_dpll_8k_i(a8),
    .auxiliary_dpll_2k_i(a2), .out3_en_i(out3_en_i), .out3_clk_i(o3),
    .external_sync_input_i(ext), .ref_is_38m88_i(ref_is_38m88_i), .frame_sync_output_o(fr),
    .multiframe_sync_output_o(mf), .gen_8k_o(g8), .gen_2k_o(g2), .sync_resync_o(rs),
    .clocks_resync_o(crs), .sample_rate_sel_o(rate), .sample_delay_o(dly));
  always #10 clk_sys_i = ~clk_sys_i;
  task chk(input [31:0] got, input [31:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task bus(input logic wr, input [11:0] a, input [31:0] d);
    hsel_i <= 1'b1;
    haddr_i <= a;
    hwrite_i <= wr;
    htrans_i <= `SC_HTRANS_NONSEQ;
    do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1);
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1);
    rdv = hrdata_o;
  endtask
  task pulse_width(input logic sel);
    if (sel) @(posedge m2); else @(posedge m8);
    for (n = 0; n < 20 && (sel ? mf : fr) !== 1'b1; n++) @(posedge clk_sys_i);
    for (w = 0; w < 50 && (sel ? mf : fr) === 1'b1; w++) @(posedge clk_sys_i);
    chk(w, O3_CYCLES);
  endtask
  initial begin
    repeat (20) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    @(posedge clk_sys_i);
    bus(0, `SC_ADDR_PHASE, 0); chk(rdv, 32'h0);
    bus(1, `SC_ADDR_PULSE, 32'hffffffff); bus(0, `SC_ADDR_PULSE, 0); chk(rdv, 32'h8f);
    bus(1, `SC_ADDR_PHASE, 32'hffffffff); bus(0, `SC_ADDR_PHASE, 0); chk(rdv, 32'hc3);
    bus(0, 12'h00c, 0); chk(rdv, 32'h0);
    $display("register test done");
    for (i = 0; i < 8; i++) begin
      bus(1, `SC_ADDR_PULSE, {24'h0, i[2], 3'h0, i[1], 1'b0, i[0], 1'b0});
      if (i[2]) @(posedge a8); else @(posedge m8);
      repeat (8) @(posedge clk_sys_i);
      chk(32'(g8), 32'(i[2] ? a8 : m8));
      chk(32'(g2), 32'(i[2] ? a2 : m2));
      chk(32'(fr), 32'((i[2] ? a8 : m8) ^ i[1]));
      chk(32'(mf), 32'((i[2] ? a2 : m2) ^ i[0]));
    end
    $display("source and shape test done");
    out3_en_i <= 1'b1;
    bus(1, `SC_ADDR_PULSE, 32'h05);
    pulse_width(0);
    pulse_width(1);
    out3_en_i <= 1'b0;
    bus(1, `SC_ADDR_PULSE, 32'h0f);
    repeat (20) @(posedge clk_sys_i);
    chk(32'(fr & mf), 32'h1);
    bus(0, `SC_ADDR_STATUS, 0); chk(rdv & 32'hffff_ffdc, 32'h0000_000c);
    $display("pulsed test done");
    for (i = 0; i < 8; i++) begin
      ref_is_38m88_i <= i[1];
      bus(1, `SC_ADDR_PHASE, {24'h0, i[2], i[0], 4'h0, i[1:0]});
      repeat (3) @(posedge clk_sys_i);
      for (n = 0; n < 400 && rs !== 1'b1; n++) @(posedge clk_sys_i);
      chk(32'(rs), 32'h1);
      chk(32'(crs), 32'(!i[2] || i[0]));
      chk(32'(rate), i[0] ? (i[1] ? 32'h2 : 32'h1) : 32'h0);
      chk(32'(dly), i[1] ? (i[0] ? 32'h3 : 32'h4) : (i[0] ? 32'h1 : 32'h2));
    end
    $display("phase test done");
    report_and_stop;
  end
  // ceiling well above the few thousand cycles the tests need
  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares = miscompares + 1;
      report_and_stop;
    end
  end
  task report_and_stop;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
endmodule // frame_sync_output_config_bench
`default_nettype wire
